// file: pkos_pkg.sv
`default_nettype none
package pkos_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint unsigned CLK_HZ        = 64'd125000000;
    localparam longint unsigned ON_HOLD_MS    = 64'd1600;
    localparam longint unsigned REQ_HOLD_MS   = 64'd600;
    localparam longint unsigned FORCE_HOLD_MS = 64'd8000;
    localparam longint unsigned DEBOUNCE_US   = 64'd10000;
    localparam longint unsigned ON_CYC_L      = (CLK_HZ * ON_HOLD_MS + 64'd999) / 64'd1000;
    localparam longint unsigned REQ_CYC_L     = (CLK_HZ * REQ_HOLD_MS + 64'd999) / 64'd1000;
    localparam longint unsigned FORCE_CYC_L   = (CLK_HZ * FORCE_HOLD_MS + 64'd999) / 64'd1000;
    localparam longint unsigned DEB_CYC_L     = (CLK_HZ * DEBOUNCE_US + 64'd999999) / 64'd1000000;

    localparam int CNT_W = 32;
    localparam logic [CNT_W-1:0] ON_CYC_D    = ON_CYC_L[CNT_W-1:0];
    localparam logic [CNT_W-1:0] REQ_CYC_D   = REQ_CYC_L[CNT_W-1:0];
    localparam logic [CNT_W-1:0] FORCE_CYC_D = FORCE_CYC_L[CNT_W-1:0];
    localparam logic [CNT_W-1:0] DEB_CYC_D   = DEB_CYC_L[CNT_W-1:0];

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [2:0] SYNC_RST = 3'h7;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_RUN_KEY,
        ST_RUN_CABLE,
        ST_SHUTDOWN
    } pkos_state_type;

endpackage
`default_nettype wire

// file: pkos_filter.sv
`timescale 1ns/100ps
`default_nettype none
module pkos_filter (
    input  wire logic                      core_clk,
    input  wire logic                      rst,
    input  wire logic                      pin_in,
    input  wire logic [pkos_pkg::CNT_W-1:0] deb_cycles,
    output logic                           level_out
);
    import pkos_pkg::*;

    // ------------------------------------------------------------
    // three-stage synchroniser and stable-time filter
    // ------------------------------------------------------------
    logic [2:0]       sync_r;
    logic [CNT_W-1:0] stable_r;
    logic             level_r;
    wire              agree    = (sync_r[1] == sync_r[2]);
    wire              differs  = agree && (sync_r[2] != level_r);
    wire              stable_done = (stable_r >= deb_cycles - 32'h1);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sync_r   <= SYNC_RST;
            stable_r <= '0;
            level_r  <= 1'b1;
        end else begin
            sync_r   <= {sync_r[1:0], pin_in};
            stable_r <= (differs && !stable_done) ? stable_r + 32'h1 : '0;
            if (differs && stable_done)
                level_r <= sync_r[2];
        end
    end

    assign level_out = level_r;
endmodule
`default_nettype wire

// file: pkos_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module pkos_sequencer #(
    parameter logic [pkos_pkg::CNT_W-1:0] ON_CYC    = pkos_pkg::ON_CYC_D,
    parameter logic [pkos_pkg::CNT_W-1:0] REQ_CYC   = pkos_pkg::REQ_CYC_D,
    parameter logic [pkos_pkg::CNT_W-1:0] FORCE_CYC = pkos_pkg::FORCE_CYC_D,
    parameter logic [pkos_pkg::CNT_W-1:0] DEB_CYC   = pkos_pkg::DEB_CYC_D
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic power_key_n,
    input  wire logic cable_turn_on_n,
    input  wire logic undervolt,
    input  wire logic download_force,
    input  wire logic sw_off_confirm,
    input  wire logic sw_off_cancel,
    output logic      power_on,
    output logic      turn_on_pulse,
    output logic      off_request,
    output logic      forced_off_pulse,
    output logic      download_mode,
    output logic      cable_locked
);
    import pkos_pkg::*;

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    logic key_lvl;
    logic cable_lvl;
    logic [2:0] uv_sync_r;
    logic [2:0] dl_sync_r;

    pkos_filter u_key_filt (
        .core_clk   (core_clk),
        .rst        (rst),
        .pin_in     (power_key_n),
        .deb_cycles (DEB_CYC),
        .level_out  (key_lvl)
    );

    pkos_filter u_cable_filt (
        .core_clk   (core_clk),
        .rst        (rst),
        .pin_in     (cable_turn_on_n),
        .deb_cycles (DEB_CYC),
        .level_out  (cable_lvl)
    );

    logic uv_r;
    logic dl_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            uv_sync_r <= 3'h0;
            dl_sync_r <= 3'h0;
            uv_r      <= 1'b0;
            dl_r      <= 1'b0;
        end else begin
            uv_sync_r <= {uv_sync_r[1:0], undervolt};
            dl_sync_r <= {dl_sync_r[1:0], download_force};
            if (uv_sync_r[1] == uv_sync_r[2])
                uv_r <= uv_sync_r[2];
            if (dl_sync_r[1] == dl_sync_r[2])
                dl_r <= dl_sync_r[2];
        end
    end

    // ------------------------------------------------------------
    // hold timer
    // ------------------------------------------------------------
    logic [CNT_W-1:0] hold_r;
    logic             acted_r;
    logic             woke_r;
    wire key_down  = !key_lvl;
    wire hold_sat  = (hold_r == FORCE_CYC);
    wire hit_on    = key_down && (hold_r == ON_CYC - 32'h1);
    wire hit_req   = key_down && (hold_r == REQ_CYC - 32'h1);
    wire hit_force = key_down && (hold_r == FORCE_CYC - 32'h1);

    always_ff @(posedge core_clk) begin
        if (rst || !key_down)
            hold_r <= '0;
        else if (!hold_sat)
            hold_r <= hold_r + 32'h1;
    end

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    pkos_state_type state_r;
    pkos_state_type state_nxt;
    logic off_req_r;
    logic off_req_nxt;
    logic dl_mode_r;

    wire run_any    = (state_r == ST_RUN_KEY) || (state_r == ST_RUN_CABLE);
    wire start_key  = (state_r == ST_OFF) && hit_on && !acted_r && !uv_r && cable_lvl;
    wire start_cbl  = (state_r == ST_OFF) && !cable_lvl && !uv_r;
    wire start_any  = start_cbl || start_key;
    wire do_force   = (state_r == ST_RUN_KEY) && hit_force && !woke_r;
    wire do_req     = (state_r == ST_RUN_KEY) && hit_req && !acted_r;
    wire do_uv      = run_any && uv_r;

    always_comb begin
        state_nxt   = state_r;
        off_req_nxt = off_req_r;
        case (state_r)
            ST_OFF: begin
                if (start_cbl)
                    state_nxt = ST_RUN_CABLE;
                else if (start_key)
                    state_nxt = ST_RUN_KEY;
            end
            ST_RUN_KEY: begin
                if (do_uv || do_force) begin
                    state_nxt   = ST_SHUTDOWN;
                    off_req_nxt = 1'b0;
                end else if (!cable_lvl) begin
                    state_nxt   = ST_RUN_CABLE;
                    off_req_nxt = 1'b0;
                end else if (off_req_r && sw_off_confirm) begin
                    state_nxt   = ST_SHUTDOWN;
                    off_req_nxt = 1'b0;
                end else if (do_req) begin
                    off_req_nxt = 1'b1;
                end else if (sw_off_cancel) begin
                    off_req_nxt = 1'b0;
                end
            end
            ST_RUN_CABLE: begin
                off_req_nxt = 1'b0;
                if (do_uv)
                    state_nxt = ST_SHUTDOWN;
            end
            ST_SHUTDOWN: state_nxt = ST_OFF;
            default:     state_nxt = ST_OFF;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r   <= ST_OFF;
            off_req_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            off_req_r <= off_req_nxt;
        end
    end

    // one turn-on or off request per press: set on key turn-on or off request, cleared on release
    always_ff @(posedge core_clk) begin
        if (rst || !key_down)
            acted_r <= 1'b0;
        else if (start_key || do_req)
            acted_r <= 1'b1;
    end

    // a press that turned the module on cannot also force it off
    always_ff @(posedge core_clk) begin
        if (rst || !key_down)
            woke_r <= 1'b0;
        else if (start_key)
            woke_r <= 1'b1;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic on_pulse_r;
    logic force_pulse_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dl_mode_r     <= 1'b0;
            on_pulse_r    <= 1'b0;
            force_pulse_r <= 1'b0;
        end else begin
            on_pulse_r    <= start_any;
            force_pulse_r <= do_force;
            if (start_any)
                dl_mode_r <= dl_r;
            else if (state_r == ST_SHUTDOWN)
                dl_mode_r <= 1'b0;
        end
    end

    assign power_on         = run_any;
    assign turn_on_pulse    = on_pulse_r;
    assign off_request      = off_req_r;
    assign forced_off_pulse = force_pulse_r;
    assign download_mode    = dl_mode_r;
    assign cable_locked     = (state_r == ST_RUN_CABLE);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_key_turn_on: assert property (
        start_key |=> (state_r == ST_RUN_KEY) && turn_on_pulse)
        else $error("key hold did not start turn-on");
    a_on_needs_hold: assert property (
        ($past(state_r) == ST_OFF) && (state_r == ST_RUN_KEY) |-> ($past(hold_r) == ON_CYC - 32'h1))
        else $error("key turn-on without full hold");
    a_req_raise: assert property (
        do_req && !do_force && !do_uv && cable_lvl && !off_req_r |=> off_request)
        else $error("shutdown request not raised");
    a_force_off: assert property (
        do_force |=> forced_off_pulse && (state_r == ST_SHUTDOWN) ##1 !power_on)
        else $error("forced shutdown missing");
    a_cable_on: assert property (
        start_cbl |=> (state_r == ST_RUN_CABLE) && power_on)
        else $error("cable turn-on missing");
    a_cable_hold: assert property (
        cable_locked && !uv_r |=> cable_locked && !off_request)
        else $error("cable run left without supply loss");
    a_uv_off: assert property (
        do_uv |=> (state_r == ST_SHUTDOWN) ##1 !power_on)
        else $error("undervoltage did not turn off");
    a_dl_latch: assert property (
        start_any |=> download_mode == $past(dl_r))
        else $error("download mode not latched at turn-on");
    a_release_reset: assert property (
        !key_down |=> hold_r == '0)
        else $error("hold timer not restarted");
    a_force_wins: assert property (
        do_force |=> !off_request)
        else $error("forced shutdown left request pending");

    c_key_on:    cover property (start_key);
    c_cable_on:  cover property (start_cbl);
    c_force:     cover property (do_force);
    c_sw_off:    cover property (off_req_r && sw_off_confirm && state_r == ST_RUN_KEY);
endmodule
`default_nettype wire

// file: pkos_key_host.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------
// host key driver
// --------------------
module pkos_key_host (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        press_req,
    input  wire logic [15:0] hold_cycles,
    output logic             power_key_n,
    output logic             busy
);
    localparam int SETTLE_CYC = 4;
    int settle_r;
    int hold_r;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            settle_r <= 0;
            hold_r   <= 0;
        end else begin
            if (settle_r < SETTLE_CYC) begin
                settle_r <= settle_r + 1;
            end
            if (hold_r != 0) begin
                hold_r <= hold_r - 1;
            end else if (press_req && settle_r >= SETTLE_CYC) begin
                hold_r <= int'(hold_cycles);
            end
        end
    end
    // driven low while the hold count runs, driven high when released
    assign power_key_n = (hold_r == 0);
    assign busy        = (hold_r != 0);
endmodule
`default_nettype wire

// file: pkos_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------
// bench
// --------------------
module pkos_sequencer_test;
    import pkos_pkg::*;
    logic        core_clk = 0, rst = 1, cable_n = 1, undervolt = 0, dl_force = 0;
    logic        confirm = 0, cancel = 0, press_req = 0, busy, key_n;
    logic [15:0] hold_cycles = 16'h0000;
    logic        power_on, on_pulse, off_req, force_pulse, dl_mode, locked;
    int          mismatches = 0, tests_run = 0, on_cnt = 0, force_cnt = 0;
    pkos_sequencer #(.ON_CYC(32'h14), .REQ_CYC(32'h8), .FORCE_CYC(32'h28), .DEB_CYC(32'h2)) pkos_sequencer_i (
        .core_clk(core_clk), .rst(rst), .power_key_n(key_n), .cable_turn_on_n(cable_n),
        .undervolt(undervolt), .download_force(dl_force), .sw_off_confirm(confirm),
        .sw_off_cancel(cancel), .power_on(power_on), .turn_on_pulse(on_pulse),
        .off_request(off_req), .forced_off_pulse(force_pulse), .download_mode(dl_mode),
        .cable_locked(locked));
    pkos_key_host pkos_key_host_i (.core_clk(core_clk), .rst(rst), .press_req(press_req),
        .hold_cycles(hold_cycles), .power_key_n(key_n), .busy(busy));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (on_pulse === 1'b1) on_cnt++;
        if (force_pulse === 1'b1) force_cnt++;
    end
    task automatic check(input string what, input logic exp, input logic seen);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic press(input int len);
        int guard;
        guard = 0;
        press_req = 1;
        hold_cycles = 16'(len);
        tick(1);
        press_req = 0;
        while (busy === 1'b1 && guard < 1000) begin
            tick(1);
            guard++;
        end
        if (guard >= 1000) mismatches++;
        tick(12);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic t_short;
        press(12);
        check("power_on", 1'b0, power_on);
        $display("test short press done");
    endtask
    task automatic t_key_on;
        on_cnt = 0;
        press(30);
        check("power_on", 1'b1, power_on);
        check("turn_on_pulse once", 1'b1, on_cnt == 1);
        check("off_request", 1'b0, off_req);
        check("download_mode", 1'b0, dl_mode);
        $display("test key turn-on done");
    endtask
    task automatic t_request;
        press(14);
        check("off_request", 1'b1, off_req);
        cancel = 1;
        tick(1);
        cancel = 0;
        tick(2);
        check("off_request", 1'b0, off_req);
        check("power_on", 1'b1, power_on);
        press(14);
        confirm = 1;
        tick(1);
        confirm = 0;
        tick(4);
        check("power_on", 1'b0, power_on);
        check("off_request", 1'b0, off_req);
        undervolt = 1;
        tick(10);
        undervolt = 0;
        tick(10);
        check("power_on", 1'b0, power_on);
        $display("test off request done");
    endtask
    task automatic t_force;
        press(30);
        force_cnt = 0;
        press(46);
        check("forced_off_pulse once", 1'b1, force_cnt == 1);
        check("power_on", 1'b0, power_on);
        check("off_request", 1'b0, off_req);
        $display("test forced off done");
    endtask
    task automatic t_cable;
        force_cnt = 0;
        press(30);
        check("power_on", 1'b1, power_on);
        cable_n = 0;
        tick(15);
        check("power_on", 1'b1, power_on);
        check("cable_locked", 1'b1, locked);
        press(50);
        check("power_on", 1'b1, power_on);
        check("forced_off_pulse none", 1'b1, force_cnt == 0);
        check("off_request", 1'b0, off_req);
        undervolt = 1;
        tick(10);
        check("power_on", 1'b0, power_on);
        undervolt = 0;
        tick(10);
        check("power_on", 1'b1, power_on);
        check("cable_locked", 1'b1, locked);
        undervolt = 1;
        cable_n = 1;
        tick(10);
        check("power_on", 1'b0, power_on);
        undervolt = 0;
        tick(10);
        check("power_on", 1'b0, power_on);
        $display("test cable and undervoltage done");
    endtask
    task automatic t_download;
        force_cnt = 0;
        dl_force = 1;
        tick(6);
        press(46);
        dl_force = 0;
        check("download_mode", 1'b1, dl_mode);
        check("power_on", 1'b1, power_on);
        check("forced_off_pulse none", 1'b1, force_cnt == 0);
        press(46);
        check("download_mode", 1'b0, dl_mode);
        check("forced_off_pulse once", 1'b1, force_cnt == 1);
        $display("test download strap done");
    endtask
    initial begin
        tick(16);
        rst = 0;
        tick(8);
        t_short();
        t_key_on();
        t_request();
        t_force();
        t_cable();
        t_download();
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        give_verdict();
    end
endmodule
`default_nettype wire
